// >>> rtl/eep_cfg.svh
// Constants for the serial EEPROM slave: address code, sizes and timing.
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH

// ----------------------------------------------------------------------
// Address byte layout
// ----------------------------------------------------------------------
`define EEP_DEV_CODE 4'hA
`define EEP_DEV_CODE_MSB 7
`define EEP_DEV_CODE_LSB 4
`define EEP_STRAP_MSB 3
`define EEP_STRAP_LSB 1
`define EEP_RW_BIT 0

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define EEP_AW 13
`define EEP_NARROW_TOP_BIT 12
`define EEP_PAGE_BITS 5
`define EEP_PAGE_BYTES 32
`define EEP_BASE_W 8
`define EEP_BYTE_BITS 8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EEP_CLK_MHZ 100
`define EEP_PROG_TIME_US 5000
`define EEP_PROG_CYCLES (`EEP_PROG_TIME_US * `EEP_CLK_MHZ)
`define EEP_TIMER_W 20
`define EEP_IN_W 7

`endif

// >>> rtl/eep_pkg.sv
// Types shared by the serial EEPROM slave modules.
package eep_pkg;

  // ----------------------------------------------------------------------
  // Bus protocol phases
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    EEP_IDLE,
    EEP_DEV,
    EEP_ACK_DEV,
    EEP_WA_HI,
    EEP_ACK_HI,
    EEP_WA_LO,
    EEP_ACK_LO,
    EEP_WDATA,
    EEP_ACK_WD,
    EEP_RDATA,
    EEP_RACK
  } eep_link_e;

  // ----------------------------------------------------------------------
  // Program engine phases
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    EEP_PG_IDLE,
    EEP_PG_STORE,
    EEP_PG_WAIT
  } eep_prog_e;

endpackage : eep_pkg

// >>> rtl/eep_prog_if.sv
// Carrier between the protocol engine and the page program engine.
`timescale 1ns/1ns
interface eep_prog_if;
  logic buf_we;
  logic [4:0] buf_idx;
  logic [7:0] buf_data;
  logic clr;
  logic launch;
  logic [7:0] page_base;
  logic busy;

  modport link (
    output buf_we,
    output buf_idx,
    output buf_data,
    output clr,
    output launch,
    output page_base,
    input busy
  );

  modport prog (
    input buf_we,
    input buf_idx,
    input buf_data,
    input clr,
    input launch,
    input page_base,
    output busy
  );
endinterface : eep_prog_if

// >>> rtl/eep_prog.sv
// Page buffer and internal write cycle engine of the serial EEPROM slave.
`timescale 1ns/1ns
`include "eep_cfg.svh"
module eep_prog #(
  parameter int unsigned PROG_CYCLES = `EEP_PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  eep_prog_if.prog pif,
  output logic mem_we,
  output logic [`EEP_AW-1:0] mem_wa,
  output logic [7:0] mem_wd
);

  eep_pkg::eep_prog_e st_ff;
  logic [7:0] page_ff [`EEP_PAGE_BYTES];
  logic [`EEP_PAGE_BYTES-1:0] valid_ff;
  logic [4:0] idx_ff;
  logic [7:0] base_ff;
  logic [`EEP_TIMER_W-1:0] tmr_ff;
  logic busy_ff;

  assign pif.busy = busy_ff;

  // ----------------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------------
  // R10 received slots
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= '0;
    end else if (ce) begin
      if (pif.clr || (st_ff == eep_pkg::EEP_PG_WAIT)) begin
        valid_ff <= '0;
      end else if (pif.buf_we) begin
        valid_ff[pif.buf_idx] <= 1'b1;
      end
    end
  end

  // R9 overwrite in page
  always_ff @(posedge clk) begin
    if (ce && pif.buf_we) begin
      page_ff[pif.buf_idx] <= pif.buf_data;
    end
  end

  // ----------------------------------------------------------------------
  // Program sequence
  // ----------------------------------------------------------------------
  // R26 bounded write cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= eep_pkg::EEP_PG_IDLE;
      idx_ff <= 5'h00;
      base_ff <= 8'h00;
      tmr_ff <= '0;
      busy_ff <= 1'b0;
      mem_we <= 1'b0;
      mem_wa <= '0;
      mem_wd <= 8'h00;
    end else if (ce) begin
      mem_we <= 1'b0;
      unique case (st_ff)
        eep_pkg::EEP_PG_IDLE: begin
          if (pif.launch && (|valid_ff)) begin
            st_ff <= eep_pkg::EEP_PG_STORE;
            base_ff <= pif.page_base;
            idx_ff <= 5'h00;
            busy_ff <= 1'b1;
          end
        end
        eep_pkg::EEP_PG_STORE: begin
          mem_we <= valid_ff[idx_ff];
          mem_wa <= {base_ff, idx_ff};
          mem_wd <= page_ff[idx_ff];
          idx_ff <= idx_ff + 5'h01;
          if (idx_ff == 5'h1F) begin
            st_ff <= eep_pkg::EEP_PG_WAIT;
            tmr_ff <= '0;
          end
        end
        eep_pkg::EEP_PG_WAIT: begin
          tmr_ff <= tmr_ff + 1'b1;
          if (tmr_ff >= `EEP_TIMER_W'(PROG_CYCLES - 1)) begin
            st_ff <= eep_pkg::EEP_PG_IDLE;
            busy_ff <= 1'b0;
          end
        end
      endcase
    end
  end

endmodule : eep_prog

// >>> rtl/eep_top.sv
// Protocol and access logic of a two-wire serial EEPROM slave.
// What this block does
// R1 - Byte units, receiver acknowledges on ninth clock.
// R2 - Ignore all traffic during internal write cycle.
// R3 - Accept only device type code 1010.
// R4 - Match three strap bits before acknowledging.
// R5 - Master opens with start, address, direction.
// R6 - Byte write: ack header, addresses, data; stop programs.
// R7 - Word address bit twelve ignored in small variant.
// R8 - Page write accepts up to 32 bytes.
// R9 - Only low five address bits wrap on writes.
// R10 - Program only the locations actually received.
// R11 - Write guard high blocks all writes.
// R12 - Master holds write guard steady during writes.
// R13 - Under write guard, data bytes get no ack.
// R14 - Acknowledge polling reveals write cycle completion.
// R15 - Master polls preferably with read direction.
// R16 - Address counter persists across all transactions.
// R17 - Read header: ack, send byte n, counter n+1.
// R18 - Master ends read with no ack, stop.
// R19 - Reads bump full counter after eighth bit.
// R20 - Random read uses dummy write then restart.
// R21 - Master ack fetches next byte endlessly.
// R22 - Sequential read wraps top address to zero.
// R23 - Start and stop are SDA edges, SCL high.
// R24 - Data changes only while SCL low.
// R25 - Stop during read aborts to standby.
// R26 - Internal write cycle ends within 5 ms.
// R27 - Counter is 12 or 13 bits by variant.
`timescale 1ns/1ns
`include "eep_cfg.svh"
module eep_top #(
  parameter int unsigned PROG_CYCLES = `EEP_PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wp,
  input wire logic strap_addr_bit0,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit2,
  input wire logic wide_array,
  output logic [`EEP_AW-1:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  output logic mem_we,
  output logic [`EEP_AW-1:0] mem_wa,
  output logic [7:0] mem_wd,
  output logic busy
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [`EEP_IN_W-1:0] in_meta_ff;
  logic [`EEP_IN_W-1:0] in_sync_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic wide_s;
  logic [2:0] strap_s;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_ff <= 7'h03;
      in_sync_ff <= 7'h03;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else if (ce) begin
      in_meta_ff <= {wide_array, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0, wp, sda_in, scl};
      in_sync_ff <= in_meta_ff;
      scl_d_ff <= in_sync_ff[0];
      sda_d_ff <= in_sync_ff[1];
    end
  end

  assign scl_s = in_sync_ff[0];
  assign sda_s = in_sync_ff[1];
  assign wp_s = in_sync_ff[2];
  assign strap_s = in_sync_ff[5:3];
  assign wide_s = in_sync_ff[6];

  // ----------------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------------
  eep_prog_if pif ();
  eep_pkg::eep_link_e st_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shreg_ff;
  logic [7:0] addr_hi_ff;
  logic [7:0] rd_shift_ff;
  logic [`EEP_AW-1:0] addr_ff;
  logic busy_ff;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  logic rx_state;
  logic byte_done;
  logic dev_match;
  logic byte_ack;
  logic rd_last_bit;
  logic wr_accept;

  // R23 start and stop
  assign start_ev = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_ev = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  // R24 data on SCL edges
  assign scl_rise = scl_s && !scl_d_ff;
  assign scl_fall = !scl_s && scl_d_ff;

  assign rx_state = (st_ff == eep_pkg::EEP_DEV) || (st_ff == eep_pkg::EEP_WA_HI) ||
                    (st_ff == eep_pkg::EEP_WA_LO) || (st_ff == eep_pkg::EEP_WDATA);
  // R1 ack after eight bits
  assign byte_done = rx_state && scl_fall && (bit_cnt_ff == 4'h8);
  // R3 device type code
  // R4 strap comparison
  assign dev_match = (shreg_ff[`EEP_DEV_CODE_MSB:`EEP_DEV_CODE_LSB] == `EEP_DEV_CODE) &&
                     (shreg_ff[`EEP_STRAP_MSB:`EEP_STRAP_LSB] == strap_s);
  // R11 guard blocks writes
  assign wr_accept = (st_ff == eep_pkg::EEP_WDATA) && byte_done && !wp_s;
  // R13 no data ack
  assign byte_ack = (st_ff == eep_pkg::EEP_DEV) ? dev_match :
                    (st_ff == eep_pkg::EEP_WDATA) ? !wp_s : 1'b1;
  assign rd_last_bit = (st_ff == eep_pkg::EEP_RDATA) && scl_fall && (bit_cnt_ff == 4'h7);

  // ----------------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------------
  // R7 bit twelve ignored
  function automatic logic [`EEP_AW-1:0] eep_mask(input logic [`EEP_AW-1:0] a, input logic wide);
    logic [`EEP_AW-1:0] r;
    r = a;
    if (!wide) begin
      r[`EEP_NARROW_TOP_BIT] = 1'b0;
    end
    return r;
  endfunction : eep_mask

  // ----------------------------------------------------------------------
  // Protocol sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= eep_pkg::EEP_IDLE;
      bit_cnt_ff <= 4'h0;
      shreg_ff <= 8'h00;
    end else if (ce) begin
      if (start_ev) begin
        // R2 ignore while busy
        st_ff <= busy_ff ? eep_pkg::EEP_IDLE : eep_pkg::EEP_DEV;
        bit_cnt_ff <= 4'h0;
      end else if (stop_ev) begin
        // R25 stop aborts read
        st_ff <= eep_pkg::EEP_IDLE;
      end else begin
        unique case (st_ff)
          eep_pkg::EEP_IDLE: begin
            bit_cnt_ff <= 4'h0;
          end
          eep_pkg::EEP_DEV, eep_pkg::EEP_WA_HI, eep_pkg::EEP_WA_LO, eep_pkg::EEP_WDATA: begin
            if (scl_rise && (bit_cnt_ff != 4'h8)) begin
              shreg_ff <= {shreg_ff[6:0], sda_s};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            if (byte_done) begin
              unique case (st_ff)
                eep_pkg::EEP_DEV: st_ff <= dev_match ? eep_pkg::EEP_ACK_DEV : eep_pkg::EEP_IDLE;
                eep_pkg::EEP_WA_HI: st_ff <= eep_pkg::EEP_ACK_HI;
                eep_pkg::EEP_WA_LO: st_ff <= eep_pkg::EEP_ACK_LO;
                default: st_ff <= eep_pkg::EEP_ACK_WD;
              endcase
            end
          end
          eep_pkg::EEP_ACK_DEV: begin
            if (scl_fall) begin
              bit_cnt_ff <= 4'h0;
              // R17 read header
              st_ff <= shreg_ff[`EEP_RW_BIT] ? eep_pkg::EEP_RDATA : eep_pkg::EEP_WA_HI;
            end
          end
          eep_pkg::EEP_ACK_HI: begin
            if (scl_fall) begin
              bit_cnt_ff <= 4'h0;
              st_ff <= eep_pkg::EEP_WA_LO;
            end
          end
          eep_pkg::EEP_ACK_LO, eep_pkg::EEP_ACK_WD: begin
            if (scl_fall) begin
              bit_cnt_ff <= 4'h0;
              // R8 more data bytes
              st_ff <= eep_pkg::EEP_WDATA;
            end
          end
          eep_pkg::EEP_RDATA: begin
            if (scl_fall) begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == 4'h7) begin
                st_ff <= eep_pkg::EEP_RACK;
              end
            end
          end
          eep_pkg::EEP_RACK: begin
            if (scl_rise && sda_s) begin
              // R18 master ends read
              st_ff <= eep_pkg::EEP_IDLE;
            end else if (scl_fall) begin
              // R21 next byte
              bit_cnt_ff <= 4'h0;
              st_ff <= eep_pkg::EEP_RDATA;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // High word address byte
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_hi_ff <= 8'h00;
    end else if (ce && byte_done && (st_ff == eep_pkg::EEP_WA_HI)) begin
      addr_hi_ff <= shreg_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Address counter
  // ----------------------------------------------------------------------
  // R16 counter persists
  // R27 counter width
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= '0;
    end else if (ce) begin
      if (byte_done && (st_ff == eep_pkg::EEP_WA_LO)) begin
        // R20 dummy write loads
        addr_ff <= eep_mask({addr_hi_ff[4:0], shreg_ff}, wide_s);
      end else if (wr_accept) begin
        // R9 low bits wrap
        addr_ff <= {addr_ff[`EEP_AW-1:`EEP_PAGE_BITS], addr_ff[4:0] + 5'h01};
      end else if (rd_last_bit) begin
        // R19 read increment
        // R22 wrap to zero
        addr_ff <= eep_mask(addr_ff + 1'b1, wide_s);
      end
    end
  end

  assign mem_rd_addr = addr_ff;

  // ----------------------------------------------------------------------
  // SDA driver
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      rd_shift_ff <= 8'h00;
    end else if (ce) begin
      sda_out <= 1'b0;
      if (start_ev || stop_ev || busy_ff) begin
        sda_oe <= 1'b0;
      end else if (byte_done) begin
        // R1 drive ack
        sda_oe <= byte_ack;
      end else if (scl_fall) begin
        if (((st_ff == eep_pkg::EEP_ACK_DEV) && shreg_ff[`EEP_RW_BIT]) || (st_ff == eep_pkg::EEP_RACK)) begin
          // R17 send byte n
          sda_oe <= !mem_rd_data[7];
          rd_shift_ff <= {mem_rd_data[6:0], 1'b0};
        end else if ((st_ff == eep_pkg::EEP_RDATA) && (bit_cnt_ff != 4'h7)) begin
          sda_oe <= !rd_shift_ff[7];
          rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
        end else begin
          sda_oe <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Page buffer feed and launch
  // ----------------------------------------------------------------------
  logic buf_we_ff;
  logic [4:0] buf_idx_ff;
  logic [7:0] buf_data_ff;
  logic clr_ff;
  logic launch_ff;
  logic [7:0] base_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_we_ff <= 1'b0;
      buf_idx_ff <= 5'h00;
      buf_data_ff <= 8'h00;
      clr_ff <= 1'b0;
      launch_ff <= 1'b0;
      base_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else if (ce) begin
      busy_ff <= pif.busy;
      // R10 store received bytes
      buf_we_ff <= wr_accept;
      buf_idx_ff <= addr_ff[4:0];
      buf_data_ff <= shreg_ff;
      clr_ff <= byte_done && (st_ff == eep_pkg::EEP_WA_LO);
      // R6 stop launches write
      launch_ff <= stop_ev && ((st_ff == eep_pkg::EEP_WDATA) || (st_ff == eep_pkg::EEP_ACK_WD));
      base_ff <= addr_ff[`EEP_AW-1:`EEP_PAGE_BITS];
    end
  end

  assign pif.buf_we = buf_we_ff;
  assign pif.buf_idx = buf_idx_ff;
  assign pif.buf_data = buf_data_ff;
  assign pif.clr = clr_ff;
  assign pif.launch = launch_ff;
  assign pif.page_base = base_ff;
  // R14 busy withholds ack
  assign busy = busy_ff;

  // ----------------------------------------------------------------------
  // Program engine
  // ----------------------------------------------------------------------
  eep_prog #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_prog (
    .clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .pif(pif.prog),
    .mem_we(mem_we),
    .mem_wa(mem_wa),
    .mem_wd(mem_wd)
  );

endmodule : eep_top

// >>> bench/eep_checker.sv
// Port checks for the serial EEPROM slave.
`timescale 1ns/1ns
`include "eep_cfg.svh"
module eep_checker #(
  parameter int unsigned PROG_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic wp,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic mem_we,
  input wire logic [`EEP_AW-1:0] mem_wa,
  input wire logic busy
);
  localparam int BUSY_MAX = PROG_CYCLES + 40;
  logic [13:0] wp_cnt_ff;
  logic [19:0] busy_cnt_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----
  // Helper counters
  // ----
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wp_cnt_ff <= 14'h0000;
    end else begin
      wp_cnt_ff <= !wp ? 14'h0000 : wp_cnt_ff + 14'(~&wp_cnt_ff);
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_ff <= 20'h00000;
    end else begin
      busy_cnt_ff <= !busy ? 20'h00000 : busy_cnt_ff + 20'h00001;
    end
  end
  // ----
  // Assertions
  // ----
  AST_OE_PULLS_LOW: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  AST_ACK_HELD: assert property ($rose(scl) && sda_oe |=> sda_oe [*6])
    else $error("low level dropped while clock high");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl && !$past(scl))
    else $error("data pin changed while clock high");
  AST_NO_ACK_BUSY: assert property (busy |-> !sda_oe)
    else $error("pin driven during write cycle");
  AST_WE_IN_CYCLE: assert property (mem_we |-> ##[0:4] busy)
    else $error("array write outside write cycle");
  AST_WE_GUARD: assert property (mem_we |-> wp_cnt_ff < 14'h2000)
    else $error("array write while guarded");
  AST_PAGE_SCAN: assert property (mem_we && $past(mem_we) |->
    mem_wa > $past(mem_wa) && (mem_wa ^ $past(mem_wa)) < 13'h0020)
    else $error("write scan left its page");
  AST_BUSY_BOUND: assert property (busy_cnt_ff <= BUSY_MAX)
    else $error("write cycle too long");
  AST_BUSY_AT_STOP: assert property ($rose(busy) |-> scl && $past(scl, 3))
    else $error("write cycle began without stop");
  AST_CYCLE_UNGUARDED: assert property ($rose(busy) |-> !$past(wp, 8))
    else $error("write cycle began while guarded");
  COV_CYCLE: cover property ($rose(busy));
  COV_SCAN: cover property (mem_we && $past(mem_we));
  COV_ACK: cover property (sda_oe && scl);
endmodule : eep_checker
bind eep_top eep_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.core_clk(core_clk), .nrst(nrst), .scl(scl),
  .wp(wp), .sda_out(sda_out), .sda_oe(sda_oe), .mem_we(mem_we), .mem_wa(mem_wa), .busy(busy));

// >>> bench/eep_i2c_master.sv
// Two-wire bus master model clocked by its own link clock.
`timescale 1ns/1ns
module eep_i2c_master (
  input wire logic link_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick();
    repeat (4) @(posedge link_clk);
  endtask : tick
  task automatic start();
    @(posedge link_clk);
    sda_drv <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_drv <= 1'b0;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start
  task automatic stop();
    sda_drv <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_drv <= 1'b1;
    tick();
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    sh = {tx, nine};
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= sh[i];
      tick();
      scl <= 1'b1;
      tick();
      sh[i] = sda;
      tick();
      scl <= 1'b0;
      tick();
    end
    rx = sh[8:1];
    ack = !sh[0];
  endtask : xfer
endmodule : eep_i2c_master

// >>> bench/test_serial_eeprom_i2c_slave.sv
// Self-checking bench for the serial EEPROM slave.
`timescale 1ns/1ns
module test_serial_eeprom_i2c_slave;
  typedef struct packed {
    logic [2:0] strap;
    logic [7:0] hdr;
    logic ack;
  } eep_row_s;
  eep_row_s rows [7] = '{'{3'h5, 8'hAA, 1'b1}, '{3'h5, 8'hBA, 1'b0}, '{3'h5, 8'h2B, 1'b0},
    '{3'h5, 8'hA2, 1'b0}, '{3'h1, 8'hA3, 1'b1}, '{3'h6, 8'hAD, 1'b1}, '{3'h6, 8'hAB, 1'b0}};
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst, ce, wp, wide_array, scl, sda_drv, sda_out, sda_oe, sda, mem_we, busy, ack;
  logic [2:0] strap;
  logic [12:0] mem_rd_addr, mem_wa, ptr;
  logic [7:0] mem_rd_data, mem_wd, rx;
  logic [7:0] mem [0:8191];
  logic [7:0] ref_m [0:8191];
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int we_cnt = 0;
  int base;
  assign sda = sda_drv & ~(sda_oe & ~sda_out);
  assign mem_rd_data = mem[mem_rd_addr];
  always @(posedge core_clk) begin
    if (mem_we === 1'b1) begin
      mem[mem_wa] <= mem_wd;
      we_cnt <= we_cnt + 1;
    end
  end
  eep_top #(.PROG_CYCLES(50)) DUT (.core_clk(core_clk), .nrst(nrst), .ce(ce), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
    .strap_addr_bit2(strap[2]), .wide_array(wide_array), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .mem_we(mem_we), .mem_wa(mem_wa), .mem_wd(mem_wd), .busy(busy));
  eep_i2c_master bm (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  task automatic close_out();
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  function automatic logic [12:0] mask();
    return wide_array ? 13'h1FFF : 13'h0FFF;
  endfunction : mask
  task automatic head(input logic [7:0] hdr, input logic want);
    bm.start();
    bm.xfer(hdr, 1'b1, rx, ack);
    check(16'(ack), 16'(want));
  endtask : head
  task automatic seek(input logic [15:0] a);
    head({4'hA, strap, 1'b0}, 1'b1);
    bm.xfer(a[15:8], 1'b1, rx, ack);
    check(16'(ack), 16'h0001);
    bm.xfer(a[7:0], 1'b1, rx, ack);
    check(16'(ack), 16'h0001);
    ptr = a[12:0] & mask();
  endtask : seek
  task automatic rd_bytes(input int n, input logic last);
    head({4'hA, strap, 1'b1}, 1'b1);
    for (int k = 0; k < n; k++) begin
      bm.xfer(8'hFF, (k == n - 1) ? last : 1'b0, rx, ack);
      check(16'(rx), 16'(ref_m[ptr]));
      ptr = (ptr + 13'h0001) & mask();
    end
    bm.stop();
    check(16'({sda_oe, mem_rd_addr}), 16'(ptr));
  endtask : rd_bytes
  task automatic wr(input logic [15:0] a, input int n);
    seek(a);
    for (int k = 0; k < n; k++) begin
      bm.xfer(8'h10 + 8'(k), 1'b1, rx, ack);
      check(16'(ack), 16'h0001);
      ref_m[{ptr[12:5], 5'(ptr[4:0] + 5'(k))}] = 8'h10 + 8'(k);
    end
    ptr = {ptr[12:5], 5'(ptr[4:0] + 5'(n))};
    base = we_cnt;
    bm.stop();
    repeat (4) @(negedge core_clk);
    check(16'(busy), 16'h0001);
    head({4'hA, strap, 1'b1}, 1'b0);
    bm.stop();
    check(16'(we_cnt - base), 16'((n > 32) ? 32 : n));
    rd_bytes(1, 1'b1);
  endtask : wr
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    wp = 1'b0;
    strap = 3'h5;
    wide_array = 1'b1;
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'h80 | 8'(i * 3);
      ref_m[i] = 8'h80 | 8'(i * 3);
    end
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    repeat (8) @(negedge core_clk);
    check(16'({sda_oe, busy, mem_rd_addr}), 16'h0000);
    ptr = 13'h0000;
    foreach (rows[i]) begin
      @(negedge core_clk);
      strap = rows[i].strap;
      repeat (4) @(negedge core_clk);
      head(rows[i].hdr, rows[i].ack);
      if (rows[i].ack && rows[i].hdr[0]) begin
        bm.xfer(8'hFF, 1'b1, rx, ack);
        check(16'(rx), 16'(ref_m[ptr]));
        ptr++;
      end
      bm.stop();
    end
    check(16'(mem_rd_addr), 16'(ptr));
    @(negedge core_clk);
    strap = 3'h5;
    wr(16'hFF3E, 34);
    seek(16'h1F20);
    rd_bytes(33, 1'b1);
    seek(16'h1FFE);
    rd_bytes(3, 1'b1);
    seek(16'h0004);
    rd_bytes(1, 1'b0);
    rd_bytes(1, 1'b1);
    @(negedge core_clk);
    wp = 1'b1;
    seek(16'h0100);
    base = we_cnt;
    bm.xfer(8'h77, 1'b1, rx, ack);
    check(16'(ack), 16'h0000);
    bm.stop();
    repeat (20) @(negedge core_clk);
    check(16'({busy, 15'(we_cnt - base)}), 16'h0000);
    wp = 1'b0;
    rd_bytes(1, 1'b1);
    @(negedge core_clk);
    wide_array = 1'b0;
    repeat (4) @(negedge core_clk);
    wr(16'h1AC0, 1);
    seek(16'hFABF);
    rd_bytes(3, 1'b1);
    @(negedge core_clk);
    ce = 1'b0;
    head({4'hA, strap, 1'b1}, 1'b0);
    bm.stop();
    check(16'(mem_rd_addr), 16'(ptr));
    @(negedge core_clk);
    ce = 1'b1;
    repeat (4) @(negedge core_clk);
    nrst = 1'b0;
    repeat (4) @(negedge core_clk);
    check(16'({sda_oe, busy, mem_rd_addr}), 16'h0000);
    nrst = 1'b1;
    repeat (8) @(negedge core_clk);
    ptr = 13'h0000;
    rd_bytes(1, 1'b1);
    close_out();
  end
endmodule : test_serial_eeprom_i2c_slave
